// >>> gpio_port_defs.vh
`ifndef GPIO_PORT_DEFS_VH
`define GPIO_PORT_DEFS_VH

`define CORE_PORTS          31
`define STANDBY_PORTS       28

`define IO_BASE_MASK        16'hFF00
`define IO_OFFSET_W         8

`define CORE_FUNC_OFS       8'h00
`define CORE_DIR_OFS        8'h04
`define CORE_LEVEL_OFS      8'h08
`define CORE_RISE_OFS       8'h0C
`define CORE_FALL_OFS       8'h10
`define CORE_FLAGS_OFS      8'h14
`define SB_FUNC_OFS         8'h80
`define SB_DIR_OFS          8'h84
`define SB_LEVEL_OFS        8'h88
`define SB_RISE_OFS         8'h8C
`define SB_FALL_OFS         8'h90
`define SB_FLAGS_OFS        8'h94
`define SB_WAKE_OFS         8'h98

`define CORE_FUNC_RST       31'h0000_0000
`define CORE_DIR_RST        31'h7FFF_FFFF
`define SB_FUNC_RST         28'h000_0000
`define SB_DIR_RST          28'hFFF_FFFF

`define CORE_EDGE_CAP       31'h0000_00FF
`define SB_WAKE_CAP         28'h000_00CF
`define CORE_FILT_CAP       31'h0007_80FF
`define SB_FILT_CAP         28'h000_030F
`define SB_NO_NATIVE        28'h000_0005
`define SB_DUAL_NATIVE      28'h000_0000
`define CORE_STRAP_PINS     31'h0000_0000
`define SB_STRAP_PINS       28'h000_0005

`define FILTER_CYCLES       2'h3
`define STRAP_SAMPLE_EDGE   2'h2

`endif

// >>> input_conditioner.v
`timescale 1ns/100ps
`default_nettype none
`include "gpio_port_defs.vh"

module input_conditioner #(
	parameter W         = 31,
	parameter FILT_MASK = 31'h0
) (
	input  wire         sys_clk,
	input  wire         sys_rst,
	input  wire [W-1:0] pin_raw,
	output reg  [W-1:0] pin_sync,
	output reg  [W-1:0] pin_filt
);
	reg [W-1:0] meta_reg;

	always @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			meta_reg <= {W{1'b0}};
			pin_sync <= {W{1'b0}};
		end
		else
		begin
			meta_reg <= pin_raw;
			pin_sync <= meta_reg;
		end
	end

	genvar i;
	generate
		for (i = 0; i < W; i = i + 1)
		begin : bit_g
			if (FILT_MASK[i])
			begin : filt_g
				reg [1:0] cnt_reg;
				// A level must hold for several samples before it is believed.
				always @(posedge sys_clk or posedge sys_rst)
				begin
					if (sys_rst)
					begin
						cnt_reg     <= 2'h0;
						pin_filt[i] <= 1'b0;
					end
					else if (pin_sync[i] == pin_filt[i])
						cnt_reg <= 2'h0;
					else if (cnt_reg == `FILTER_CYCLES - 2'h1)
					begin
						cnt_reg     <= 2'h0;
						pin_filt[i] <= pin_sync[i];
					end
					else
						cnt_reg <= cnt_reg + 2'h1;
				end
			end
			else
			begin : pass_g
				always @(posedge sys_clk or posedge sys_rst)
				begin
					if (sys_rst)
						pin_filt[i] <= 1'b0;
					else
						pin_filt[i] <= pin_sync[i];
				end
			end
		end
	endgenerate
endmodule

`default_nettype wire

// >>> edge_flags.v
`timescale 1ns/100ps
`default_nettype none

module edge_flags #(
	parameter W        = 31,
	parameter CAP_MASK = 31'h0
) (
	input  wire         sys_clk,
	input  wire         sys_rst,
	input  wire [W-1:0] level,
	input  wire [W-1:0] arm,
	input  wire [W-1:0] rise_en,
	input  wire [W-1:0] fall_en,
	input  wire         clr_wr,
	input  wire [W-1:0] clr_bits,
	output reg  [W-1:0] flags
);
	reg  [W-1:0] prev_reg;
	wire [W-1:0] hit;
	wire [W-1:0] cap = CAP_MASK;

	assign hit = cap & arm & ((rise_en & level & ~prev_reg) | (fall_en & ~level & prev_reg));

	always @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			prev_reg <= {W{1'b0}};
			flags    <= {W{1'b0}};
		end
		else
		begin
			prev_reg <= level;
			// A new edge in the clearing cycle survives the clear.
			flags <= (flags & ~({W{clr_wr}} & clr_bits)) | hit;
		end
	end
endmodule

`default_nettype wire

// >>> two_well_pin_port_mux.v
`timescale 1ns/100ps
`default_nettype none
`include "gpio_port_defs.vh"

module two_well_pin_port_mux (
	input  wire        sys_clk,
	input  wire        sys_rst,
	input  wire [15:0] port_io_base,
	input  wire [15:0] io_addr,
	input  wire        io_wr,
	input  wire        io_rd,
	input  wire [31:0] io_wdata,
	output reg  [31:0] io_rdata,
	output reg         io_rvalid,
	input  wire [30:0] core_pin_in,
	output reg  [30:0] core_pin_out,
	output reg  [30:0] core_pin_oe,
	input  wire [30:0] core_native_out,
	input  wire [30:0] core_native_oe,
	output reg  [30:0] core_native_in,
	input  wire [27:0] standby_pin_in,
	output reg  [27:0] standby_pin_out,
	output reg  [27:0] standby_pin_oe,
	input  wire [27:0] standby_native_out,
	input  wire [27:0] standby_native_oe,
	input  wire [27:0] standby_native2_out,
	input  wire [27:0] standby_native2_oe,
	input  wire [27:0] standby_alt_select,
	output reg  [27:0] standby_native_in,
	output reg         standby_wake,
	output reg  [30:0] core_strap,
	output reg  [27:0] standby_strap
);
	reg  [30:0] core_func_reg;
	reg  [30:0] core_dir_reg;
	reg  [30:0] core_level_reg;
	reg  [30:0] core_rise_reg;
	reg  [30:0] core_fall_reg;
	reg  [27:0] sb_func_reg;
	reg  [27:0] sb_dir_reg;
	reg  [27:0] sb_level_reg;
	reg  [27:0] sb_rise_reg;
	reg  [27:0] sb_fall_reg;
	reg  [27:0] sb_wake_reg;
	reg  [1:0]  strap_cnt_reg;
	reg         strap_done_reg;
	reg  [31:0] rdata_next;
	reg  [30:0] core_out_next;
	reg  [30:0] core_oe_next;
	reg  [27:0] sb_out_next;
	reg  [27:0] sb_oe_next;
	reg  [27:0] sb_nat_out;
	reg  [27:0] sb_nat_oe;

	wire [30:0] core_sync;
	wire [30:0] core_filt;
	wire [27:0] sb_sync;
	wire [27:0] sb_filt;
	wire [30:0] core_flags;
	wire [27:0] sb_flags;
	wire        in_window;
	wire [7:0]  ofs;
	wire        core_func_wr;
	wire        core_dir_wr;
	wire        core_level_wr;
	wire        core_rise_wr;
	wire        core_fall_wr;
	wire        core_clr_wr;
	wire        sb_func_wr;
	wire        sb_dir_wr;
	wire        sb_level_wr;
	wire        sb_rise_wr;
	wire        sb_fall_wr;
	wire        sb_clr_wr;
	wire        sb_wake_wr;

	// Only the window that the base register points at belongs to this block.
	assign in_window = (io_addr & `IO_BASE_MASK) == (port_io_base & `IO_BASE_MASK);
	assign ofs       = io_addr[`IO_OFFSET_W-1:0];

	// One strobe per register, decoded once; the flag strobes also drive the clear.
	assign core_func_wr  = sel(io_wr, in_window, ofs, `CORE_FUNC_OFS);
	assign core_dir_wr   = sel(io_wr, in_window, ofs, `CORE_DIR_OFS);
	assign core_level_wr = sel(io_wr, in_window, ofs, `CORE_LEVEL_OFS);
	assign core_rise_wr  = sel(io_wr, in_window, ofs, `CORE_RISE_OFS);
	assign core_fall_wr  = sel(io_wr, in_window, ofs, `CORE_FALL_OFS);
	assign core_clr_wr   = sel(io_wr, in_window, ofs, `CORE_FLAGS_OFS);
	assign sb_func_wr    = sel(io_wr, in_window, ofs, `SB_FUNC_OFS);
	assign sb_dir_wr     = sel(io_wr, in_window, ofs, `SB_DIR_OFS);
	assign sb_level_wr   = sel(io_wr, in_window, ofs, `SB_LEVEL_OFS);
	assign sb_rise_wr    = sel(io_wr, in_window, ofs, `SB_RISE_OFS);
	assign sb_fall_wr    = sel(io_wr, in_window, ofs, `SB_FALL_OFS);
	assign sb_clr_wr     = sel(io_wr, in_window, ofs, `SB_FLAGS_OFS);
	assign sb_wake_wr    = sel(io_wr, in_window, ofs, `SB_WAKE_OFS);

	function sel;
		input        en;
		input        win;
		input [7:0]  a;
		input [7:0]  target;
		begin
			sel = en & win & (a == target);
		end
	endfunction

	input_conditioner #(
		.W         (`CORE_PORTS),
		.FILT_MASK (`CORE_FILT_CAP)
	) core_cond (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.pin_raw  (core_pin_in),
		.pin_sync (core_sync),
		.pin_filt (core_filt)
	);

	input_conditioner #(
		.W         (`STANDBY_PORTS),
		.FILT_MASK (`SB_FILT_CAP)
	) sb_cond (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.pin_raw  (standby_pin_in),
		.pin_sync (sb_sync),
		.pin_filt (sb_filt)
	);

	// Edges count only on ports that software owns and has set as inputs.
	edge_flags #(
		.W        (`CORE_PORTS),
		.CAP_MASK (`CORE_EDGE_CAP)
	) core_edges (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.level    (core_filt),
		.arm      (core_func_reg & core_dir_reg),
		.rise_en  (core_rise_reg),
		.fall_en  (core_fall_reg),
		.clr_wr   (core_clr_wr),
		.clr_bits (io_wdata[30:0]),
		.flags    (core_flags)
	);

	edge_flags #(
		.W        (`STANDBY_PORTS),
		.CAP_MASK (`SB_WAKE_CAP)
	) sb_edges (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.level    (sb_filt),
		.arm      (sb_func_reg & sb_dir_reg),
		.rise_en  (sb_rise_reg),
		.fall_en  (sb_fall_reg),
		.clr_wr   (sb_clr_wr),
		.clr_bits (io_wdata[27:0]),
		.flags    (sb_flags)
	);

	// Control registers; only the bits that name real ports are stored.
	always @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			core_func_reg  <= `CORE_FUNC_RST;
			core_dir_reg   <= `CORE_DIR_RST;
			core_level_reg <= 31'h0000_0000;
			core_rise_reg  <= 31'h0000_0000;
			core_fall_reg  <= 31'h0000_0000;
			sb_func_reg    <= `SB_FUNC_RST;
			sb_dir_reg     <= `SB_DIR_RST;
			sb_level_reg   <= 28'h000_0000;
			sb_rise_reg    <= 28'h000_0000;
			sb_fall_reg    <= 28'h000_0000;
			sb_wake_reg    <= 28'h000_0000;
		end
		else
		begin
			if (core_func_wr)
				core_func_reg <= io_wdata[30:0];
			if (core_dir_wr)
				core_dir_reg <= io_wdata[30:0];
			if (core_level_wr)
				core_level_reg <= io_wdata[30:0];
			if (core_rise_wr)
				core_rise_reg <= io_wdata[30:0];
			if (core_fall_wr)
				core_fall_reg <= io_wdata[30:0];
			if (sb_func_wr)
				sb_func_reg <= io_wdata[27:0];
			if (sb_dir_wr)
				sb_dir_reg <= io_wdata[27:0];
			if (sb_level_wr)
				sb_level_reg <= io_wdata[27:0];
			if (sb_rise_wr)
				sb_rise_reg <= io_wdata[27:0];
			if (sb_fall_wr)
				sb_fall_reg <= io_wdata[27:0];
			if (sb_wake_wr)
				sb_wake_reg <= io_wdata[27:0];
		end
	end

	// Read mux; unmapped offsets and reserved bits read as zero.
	always @*
	begin
		rdata_next = 32'h0000_0000;
		if (in_window)
		begin
			case (ofs)
				`CORE_FUNC_OFS:  rdata_next = {1'b0, core_func_reg};
				`CORE_DIR_OFS:   rdata_next = {1'b0, core_dir_reg};
				`CORE_LEVEL_OFS: rdata_next = {1'b0, core_filt};
				`CORE_RISE_OFS:  rdata_next = {1'b0, core_rise_reg};
				`CORE_FALL_OFS:  rdata_next = {1'b0, core_fall_reg};
				`CORE_FLAGS_OFS: rdata_next = {1'b0, core_flags};
				`SB_FUNC_OFS:    rdata_next = {4'h0, sb_func_reg};
				`SB_DIR_OFS:     rdata_next = {4'h0, sb_dir_reg};
				`SB_LEVEL_OFS:   rdata_next = {4'h0, sb_filt};
				`SB_RISE_OFS:    rdata_next = {4'h0, sb_rise_reg};
				`SB_FALL_OFS:    rdata_next = {4'h0, sb_fall_reg};
				`SB_FLAGS_OFS:   rdata_next = {4'h0, sb_flags};
				`SB_WAKE_OFS:    rdata_next = {4'h0, sb_wake_reg};
				default:         rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			io_rdata  <= 32'h0000_0000;
			io_rvalid <= 1'b0;
		end
		else
		begin
			io_rvalid <= io_rd;
			if (io_rd)
				io_rdata <= rdata_next;
		end
	end

	// Straps are taken once the synchronisers hold the post-reset pin level.
	always @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			strap_cnt_reg  <= 2'h0;
			strap_done_reg <= 1'b0;
			core_strap     <= 31'h0000_0000;
			standby_strap  <= 28'h000_0000;
		end
		else if (!strap_done_reg)
		begin
			if (strap_cnt_reg == `STRAP_SAMPLE_EDGE)
			begin
				core_strap     <= core_sync & `CORE_STRAP_PINS;
				standby_strap  <= sb_sync & `SB_STRAP_PINS;
				strap_done_reg <= 1'b1;
			end
			else
				strap_cnt_reg <= strap_cnt_reg + 2'h1;
		end
	end

	// Pin drive. Until straps are sampled every pin stays an input, so an
	// external strap resistor is never fought by a native driver.
	always @*
	begin
		sb_nat_out    = standby_native_out;
		sb_nat_oe     = standby_native_oe;
		core_out_next = 31'h0000_0000;
		core_oe_next  = 31'h0000_0000;
		sb_out_next   = 28'h000_0000;
		sb_oe_next    = 28'h000_0000;
		if (strap_done_reg)
		begin
			sb_nat_out = (standby_alt_select & `SB_DUAL_NATIVE & standby_native2_out) |
				(~(standby_alt_select & `SB_DUAL_NATIVE) & standby_native_out);
			sb_nat_oe = ((standby_alt_select & `SB_DUAL_NATIVE & standby_native2_oe) |
				(~(standby_alt_select & `SB_DUAL_NATIVE) & standby_native_oe)) &
				~`SB_NO_NATIVE;
			core_out_next = (core_func_reg & core_level_reg) |
				(~core_func_reg & core_native_out);
			core_oe_next = (core_func_reg & ~core_dir_reg) |
				(~core_func_reg & core_native_oe);
			sb_out_next = (sb_func_reg & sb_level_reg) |
				(~sb_func_reg & sb_nat_out);
			sb_oe_next = (sb_func_reg & ~sb_dir_reg) |
				(~sb_func_reg & sb_nat_oe);
		end
	end

	always @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			core_pin_out      <= 31'h0000_0000;
			core_pin_oe       <= 31'h0000_0000;
			standby_pin_out   <= 28'h000_0000;
			standby_pin_oe    <= 28'h000_0000;
			core_native_in    <= 31'h0000_0000;
			standby_native_in <= 28'h000_0000;
			standby_wake      <= 1'b0;
		end
		else
		begin
			core_pin_out    <= core_out_next;
			core_pin_oe     <= core_oe_next;
			standby_pin_out <= sb_out_next;
			standby_pin_oe  <= sb_oe_next;
			// Native receivers see the pin only while the port is not taken over.
			core_native_in    <= core_filt & ~core_func_reg;
			standby_native_in <= sb_filt & ~sb_func_reg & ~`SB_NO_NATIVE;
			standby_wake      <= |(sb_flags & sb_wake_reg & `SB_WAKE_CAP);
		end
	end
endmodule

`default_nettype wire

// >>> two_well_pin_port_mux_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module two_well_pin_port_mux_asserts (
	input wire logic        sys_clk,
	input wire logic        sys_rst,
	input wire logic [15:0] port_io_base,
	input wire logic [15:0] io_addr,
	input wire logic        io_rd,
	input wire logic [31:0] io_rdata,
	input wire logic        io_rvalid,
	input wire logic [27:0] standby_pin_in,
	input wire logic [30:0] core_pin_oe,
	input wire logic [27:0] standby_pin_oe,
	input wire logic [27:0] standby_native_in,
	input wire logic [30:0] core_strap,
	input wire logic [27:0] standby_strap
);
	logic [2:0] cyc_reg;
	wire        hole;
	wire        sb_sel;
	assign sb_sel = io_addr[7];
	assign hole = io_addr[7:0] > 8'h9b || (io_addr[7:0] > 8'h17 && io_addr[7:0] < 8'h80)
		|| io_addr[15:8] != port_io_base[15:8];
	// Saturates so the counter stays small; only the first edges after reset matter.
	always_ff @(posedge sys_clk or posedge sys_rst)
		if (sys_rst)
			cyc_reg <= 3'h0;
		else if (cyc_reg != 3'h7)
			cyc_reg <= cyc_reg + 3'h1;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	read_answer_a:
		assert property (io_rd && io_addr[15:8] == port_io_base[15:8] |=> io_rvalid)
		else $error("read not answered");
	answer_cause_a: assert property (io_rvalid |-> $past(io_rd)) else $error("stray answer");
	rdata_hold_a: assert property (!io_rvalid |-> $stable(io_rdata)) else $error("rdata moved");
	reserved_bits_a:
		assert property (io_rvalid |-> !io_rdata[31] && (!$past(sb_sel) || io_rdata[30:28] == 3'h0))
		else $error("reserved bit set");
	hole_zero_a:
		assert property (io_rvalid && $past(hole) |-> io_rdata == 32'h0)
		else $error("unmapped read not zero");
	drive_off_a:
		assert property (cyc_reg < 3'h4 |-> core_pin_oe == 31'h0 && standby_pin_oe == 28'h000_0000)
		else $error("pin driven during strap");
	strap_value_a:
		assert property (cyc_reg == 3'h5 |-> standby_strap == (standby_pin_in & 28'h000_0005))
		else $error("strap value wrong");
	strap_hold_a: assert property (cyc_reg > 3'h4 |-> $stable(standby_strap)) else $error("strap moved");
	strap_mask_a:
		assert property (core_strap == 31'h0 && (standby_strap & 28'hfff_fffa) == 28'h000_0000)
		else $error("non strap pin captured");
	no_native_a:
		assert property (standby_native_in[0] == 1'b0 && standby_native_in[2] == 1'b0)
		else $error("native input on plain port");
endmodule
bind two_well_pin_port_mux two_well_pin_port_mux_asserts i_two_well_pin_port_mux_asserts (
	.sys_clk, .sys_rst, .port_io_base, .io_addr, .io_rd, .io_rdata, .io_rvalid, .standby_pin_in,
	.core_pin_oe, .standby_pin_oe, .standby_native_in, .core_strap, .standby_strap);
`default_nettype wire

// >>> board_pins.sv
`timescale 1ns/100ps
`default_nettype none
module board_pins #(
	parameter int W = 31
) (
	input  wire logic [W-1:0] drive,
	input  wire logic [W-1:0] drive_en,
	input  wire logic [W-1:0] ext,
	output logic      [W-1:0] pin
);
	// Board drivers are weak: wherever the device drives, its own level wins.
	assign pin = (drive & drive_en) | (ext & ~drive_en);
endmodule
`default_nettype wire

// >>> two_well_pin_port_mux_tb.sv
`timescale 1ns/100ps
`default_nettype none
module two_well_pin_port_mux_tb;
	localparam logic [15:0] BASE = 16'h0500;
	localparam logic [7:0]  RW_OFS [9] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h80, 8'h84, 8'h8c,
		8'h90, 8'h98};
	logic        sys_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        io_wr = 1'b0;
	logic        io_rd = 1'b0;
	logic        io_rvalid;
	logic        standby_wake;
	logic [15:0] io_addr = 16'h0000;
	logic [15:0] port_io_base = 16'h0500;
	logic [31:0] io_wdata = 32'h0000_0000;
	logic [31:0] io_rdata;
	logic [31:0] seed = 32'h7ec5;
	logic [31:0] v;
	logic [30:0] core_pin_in, core_pin_out, core_pin_oe, core_native_in, core_strap;
	logic [30:0] core_native_out = 31'h0, core_native_oe = 31'h0, core_ext = 31'h0;
	logic [27:0] standby_pin_in, standby_pin_out, standby_pin_oe, standby_native_in, standby_strap;
	logic [27:0] standby_native_out = 28'h0, standby_native_oe = 28'h0, standby_ext = 28'h4;
	logic [27:0] alt_sel = 28'h0;
	int          n_mismatch = 0;
	int          total_checks = 0;
	always #50 sys_clk = ~sys_clk;
	two_well_pin_port_mux i_two_well_pin_port_mux (.sys_clk, .sys_rst, .port_io_base,
		.io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .io_rvalid, .core_pin_in, .core_pin_out,
		.core_pin_oe, .core_native_out, .core_native_oe, .core_native_in, .standby_pin_in,
		.standby_pin_out, .standby_pin_oe, .standby_native_out, .standby_native_oe,
		.standby_native2_out(28'h0), .standby_native2_oe(28'h0), .standby_alt_select(alt_sel),
		.standby_native_in, .standby_wake, .core_strap, .standby_strap);
	board_pins #(.W(31)) i_board_pins (.drive(core_pin_out), .drive_en(core_pin_oe),
		.ext(core_ext), .pin(core_pin_in));
	board_pins #(.W(28)) i_board_pins_sb (.drive(standby_pin_out), .drive_en(standby_pin_oe),
		.ext(standby_ext), .pin(standby_pin_in));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	function automatic logic [31:0] mask(input logic [7:0] a);
		return a[7] ? 32'h0fff_ffff : 32'h7fff_ffff;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic ext_set(input int b, input logic [31:0] x);
		if (b)
			standby_ext <= x[27:0];
		else
			core_ext <= x[30:0];
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		io_addr <= a;
		io_wdata <= d;
		io_wr <= 1'b1;
		@(posedge sys_clk);
		io_wr <= 1'b0;
	endtask
	task automatic rdc(input logic [15:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge sys_clk);
		io_rd <= 1'b0;
		@(negedge sys_clk);
		chk({31'h0, io_rvalid}, 32'h1);
		chk(io_rdata, e);
	endtask
	task automatic results;
		$display("checks %0d, mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		repeat (5000) @(posedge sys_clk);
		n_mismatch++;
		results;
	end
	initial
	begin
		logic [7:0] o;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk({4'h0, standby_strap}, 32'h0000_0004);
		wr(16'h0604, 32'h0000_0000);
		for (int i = 0; i < 4; i++)
			rdc(BASE + {8'h0, i[1], 4'h0, i[0], 2'h0}, i[0] ? mask({i[1], 7'h0}) : 32'h0);
		rdc(BASE + 16'h0040, 32'h0000_0000);
		rdc(16'h0604, 32'h0000_0000);
		for (int i = 0; i < 9; i++)
		begin
			seed = xs(seed);
			wr(BASE + {8'h0, RW_OFS[i]}, seed);
			rdc(BASE + {8'h0, RW_OFS[i]}, seed & mask(RW_OFS[i]));
		end
		for (int b = 0; b < 2; b++)
		begin
			o = b ? 8'h80 : 8'h00;
			seed = xs(seed);
			v = xs(seed);
			@(posedge sys_clk);
			// Only the bank under test moves its pins, so the other bank sees no edge.
			ext_set(b, v);
			v = seed;
			wr(BASE + o, 32'hffff_ffff);
			wr(BASE + o + 16'h4, 32'h0000_0000);
			wr(BASE + o + 16'h8, v);
			repeat (8) @(negedge sys_clk);
			chk(b ? {4'h0, standby_pin_oe} : {1'b0, core_pin_oe}, mask(o));
			chk(b ? {4'h0, standby_pin_out} : {1'b0, core_pin_out}, v & mask(o));
			chk(b ? {4'h0, standby_native_in} : {1'b0, core_native_in}, 32'h0);
			rdc(BASE + o + 16'h8, v & mask(o));
			wr(BASE + o + 16'h4, 32'hffff_ffff);
			repeat (8) @(posedge sys_clk);
			rdc(BASE + o + 16'h8, b ? {4'h0, standby_ext} : {1'b0, core_ext});
			@(posedge sys_clk);
			ext_set(b, 32'h0000_0000);
			wr(BASE + o + 16'hc, 32'hffff_ffff);
			repeat (8) @(posedge sys_clk);
			wr(BASE + o + 16'h14, 32'hffff_ffff);
			ext_set(b, 32'hffff_ffff);
			repeat (10) @(posedge sys_clk);
			rdc(BASE + o + 16'h14, b ? 32'h0000_00cf : 32'h0000_00ff);
			wr(BASE + 16'h98, 32'hffff_ffff);
			repeat (3) @(negedge sys_clk);
			chk({31'h0, standby_wake}, b);
			wr(BASE + o + 16'h14, 32'hffff_ffff);
			rdc(BASE + o + 16'h14, 32'h0000_0000);
			chk({31'h0, standby_wake}, 32'h0);
		end
		// Standby ports 0 and 2 have no native function, so their native drive is left out.
		wr(BASE, 32'h0000_0000);
		wr(BASE + 16'h80, 32'h0000_0000);
		seed = xs(seed);
		core_native_out <= seed[30:0];
		standby_native_out <= seed[27:0];
		seed = xs(seed);
		core_native_oe <= seed[30:0];
		standby_native_oe <= seed[27:0];
		alt_sel <= ~seed[27:0];
		repeat (10) @(negedge sys_clk);
		chk({1'b0, core_pin_oe}, {1'b0, core_native_oe});
		chk({1'b0, core_pin_out & core_pin_oe}, {1'b0, core_native_out & core_native_oe});
		chk({4'h0, standby_pin_oe & 28'hfff_fffa}, {4'h0, standby_native_oe & 28'hfff_fffa});
		chk({1'b0, core_native_in}, {1'b0, core_native_out & core_native_oe | core_ext & ~core_native_oe});
		// Move the window: the new base must answer and the old one must read as zero.
		@(posedge sys_clk);
		port_io_base <= 16'h0600;
		rdc(16'h0604, 32'h7fff_ffff);
		rdc(BASE + 16'h0004, 32'h0000_0000);
		results;
	end
endmodule
`default_nettype wire
